//--- pkg/rtcss_pkg.sv
// Shared constants and types of the supply supervisor and time base.
package rtcss_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // Times in their own units.
  localparam int unsigned RECOVERY_HOLD_MS = 250;
  localparam int unsigned DEBOUNCE_MS = 250;
  localparam int unsigned BUTTON_PULSE_MS = 250;
  localparam int unsigned FIRST_MEAS_S = 2;
  localparam int unsigned BACKUP_COMP_PERIOD_S = 10;
  localparam int unsigned MAIN_COMP_PERIOD_S = 1;
  // Cycle counts derived from the clock rate.
  localparam int unsigned RECOVERY_HOLD_CYC = RECOVERY_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned BUTTON_PULSE_CYC = BUTTON_PULSE_MS * (CLK_HZ / 1000);
  localparam int unsigned TIMER_W = 32;
  localparam int unsigned TRIM_W = 8;
  localparam int unsigned CORR_W = 10;
  localparam logic [3:0] CONV_CNT_W0 = 4'h0;
  // Default calendar contents loaded on first start, in BCD.
  localparam logic [7:0] DEF_SEC = 8'h00;
  localparam logic [7:0] DEF_MIN = 8'h00;
  localparam logic [7:0] DEF_HOUR = 8'h00;
  localparam logic [2:0] DEF_WDAY = 3'h1;
  localparam logic [7:0] DEF_DATE = 8'h01;
  localparam logic [7:0] DEF_MONTH = 8'h01;
  localparam logic [7:0] DEF_YEAR = 8'h00;
  localparam logic IRQ_SEL_RESET = 1'b1;
  // Reset line supervisor states.
  typedef enum logic [5:0] {
    RTCSS_IDLE = 6'h01,
    RTCSS_PFAIL = 6'h02,
    RTCSS_RECOVER = 6'h04,
    RTCSS_DEBOUNCE = 6'h08,
    RTCSS_WAIT_RISE = 6'h10,
    RTCSS_PULSE = 6'h20
  } rtcss_rst_state_t;
endpackage

//--- hdl/rtcss_calendar.sv
// BCD calendar and clock counters advanced by a one second tick.
`timescale 1ns/1ps
`default_nettype none
module rtcss_calendar
  import rtcss_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load_default,
  input wire logic tick,
  input wire logic mode_12h,
  output logic [7:0] sec_q,
  output logic [7:0] min_q,
  output logic [7:0] hour_q,
  output logic [2:0] wday_q,
  output logic [7:0] date_q,
  output logic [7:0] month_q,
  output logic [7:0] year_q
);
  logic leap;
  logic [7:0] last_date;
  logic [7:0] hour_next;
  logic [7:0] hour_inc12;

  // Increments a BCD byte.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9)
    begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end
    else
    begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // BCD years divisible by four are leap years in this century.
  assign leap = (year_q[4] ? (year_q[1:0] == 2'h2) : (year_q[1:0] == 2'h0));

  // Hour digits without the format and afternoon flags, advanced by one.
  assign hour_inc12 = bcd_inc({3'h0, hour_q[4:0]});

  // Last day of the current month, with the leap correction for February.
  always_comb
  begin
    last_date = 8'h31;
    if (month_q == 8'h02)
    begin
      last_date = leap ? 8'h29 : 8'h28; // [RQ17]
    end
    else if (month_q == 8'h04 || month_q == 8'h06 || month_q == 8'h09 || month_q == 8'h11)
    begin
      last_date = 8'h30; // [RQ17]
    end
  end

  // Next hour value in the selected format; bit 5 is the afternoon flag in 12 hour mode.
  always_comb
  begin
    hour_next = bcd_inc(hour_q);
    if (mode_12h)
    begin
      if (hour_q[4:0] == 5'h12)
      begin
        hour_next = {hour_q[7:5], 5'h01}; // [RQ18]
      end
      else if (hour_q[4:0] == 5'h11)
      begin
        hour_next = {hour_q[7:6], ~hour_q[5], 5'h12}; // [RQ18]
      end
      else
      begin
        hour_next = {hour_q[7:5], hour_inc12[4:0]};
      end
    end
    else if (hour_q == 8'h23)
    begin
      hour_next = 8'h00; // [RQ18]
    end
  end

  // Counter chain with carries from seconds up to years.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sec_q <= DEF_SEC;
      min_q <= DEF_MIN;
      hour_q <= DEF_HOUR;
      wday_q <= DEF_WDAY;
      date_q <= DEF_DATE;
      month_q <= DEF_MONTH;
      year_q <= DEF_YEAR;
    end
    else if (load_default)
    begin
      sec_q <= DEF_SEC;
      min_q <= DEF_MIN;
      hour_q <= mode_12h ? 8'h52 : DEF_HOUR;
      wday_q <= DEF_WDAY;
      date_q <= DEF_DATE;
      month_q <= DEF_MONTH;
      year_q <= DEF_YEAR;
    end
    else if (tick)
    begin
      sec_q <= (sec_q == 8'h59) ? 8'h00 : bcd_inc(sec_q);
      if (sec_q == 8'h59)
      begin
        min_q <= (min_q == 8'h59) ? 8'h00 : bcd_inc(min_q);
        if (min_q == 8'h59)
        begin
          hour_q <= hour_next;
          if (mode_12h ? (hour_q[5:0] == 6'h31) : (hour_q == 8'h23))
          begin
            wday_q <= (wday_q == 3'h7) ? 3'h1 : wday_q + 3'h1;
            date_q <= (date_q == last_date) ? 8'h01 : bcd_inc(date_q); // [RQ17]
            if (date_q == last_date)
            begin
              month_q <= (month_q == 8'h12) ? 8'h01 : bcd_inc(month_q);
              if (month_q == 8'h12)
              begin
                year_q <= (year_q == 8'h99) ? 8'h00 : bcd_inc(year_q);
              end
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/rtcss_top.sv
// Supply selection, reset line supervisor, oscillator gating and compensation cadence.
// What this block does
// [RQ1] Correct time base each second, backup every 10s.
// [RQ2] Add signed aging offset to factory trim.
// [RQ3] Primary above threshold or backup; else backup.
// [RQ4] Convert temperature per second, backup every 10s.
// [RQ5] Power fail drives reset line low.
// [RQ6] Hold reset low for recovery after return.
// [RQ7] Oscillator stopped: skip recovery hold.
// [RQ8] Idle falling edge: pull low for debounce.
// [RQ9] Still low: await rise, then reset pulse.
// [RQ10] Reset output leaves timekeeping unaffected.
// [RQ11] Reset logic only with primary; else low.
// [RQ12] First battery attach: oscillator waits for start.
// [RQ13] Measure and correct soon after start event.
// [RQ14] Running oscillator keeps running while supplied.
// [RQ15] First start loads default time and date.
// [RQ16] Enable bar high on backup stops oscillator.
// [RQ17] Month ends and leap February roll correctly.
// [RQ18] Hours in 24 or 12 hour format.
// [RQ19] Two alarms; output selects alarm or square.
// [RQ20] Registers reached only through the serial bus.
// [RQ21] Select 0 square wave, 1 alarm irq.
// [RQ22] Synchronise reset line before edge detection.
`timescale 1ns/1ps
`default_nettype none
module rtcss_top
  import rtcss_pkg::*;
#(
  parameter int unsigned RECOVERY_CYC = RECOVERY_HOLD_CYC,
  parameter int unsigned DEBOUNCE_LEN = DEBOUNCE_CYC,
  parameter int unsigned PULSE_LEN = BUTTON_PULSE_CYC
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic primary_above_threshold,
  input wire logic primary_above_backup,
  input wire logic backup_present,
  input wire logic addr_match,
  input wire logic osc_tick_1hz,
  input wire logic temp_done,
  input wire logic [CORR_W-1:0] temp_correction,
  input wire logic [CORR_W-1:0] factory_trim,
  input wire logic signed [TRIM_W-1:0] aging_offset,
  input wire logic oscillator_enable_bar,
  input wire logic irq_output_select,
  input wire logic mode_12h,
  input wire logic alarm1_match,
  input wire logic alarm2_match,
  input wire logic alarm1_enable,
  input wire logic alarm2_enable,
  input wire logic rst_line_i,
  output logic rst_line_o,
  output logic rst_line_oe,
  output logic alarm_irq_or_square_o,
  output logic alarm_irq_or_square_oe,
  output logic on_primary_q,
  output logic power_fail_q,
  output logic osc_run_q,
  output logic temp_start_q,
  output logic corr_apply_q,
  output logic [CORR_W-1:0] corr_value_q,
  output logic [7:0] sec_q,
  output logic [7:0] min_q,
  output logic [7:0] hour_q,
  output logic [2:0] wday_q,
  output logic [7:0] date_q,
  output logic [7:0] month_q,
  output logic [7:0] year_q
);
  import rtcss_pkg::*;

  logic pa_s1_q, pa_s2_q, pb_s1_q, pb_s2_q;
  logic line_s1_q, line_s2_q, line_prev_q;
  logic tick_s1_q, tick_s2_q, tick_prev_q;
  logic fall, rise, tick;
  rtcss_rst_state_t state_q;
  logic [TIMER_W-1:0] timer_q;
  logic started_q, loaded_q, meas_pend_q;
  logic [3:0] conv_cnt_q;
  logic sq_q;
  logic alarm_flag_q;
  logic load_default;
  logic conv_due;
  logic drive_low;

  // The line is let go a few cycles before debounce ends, so the synchroniser shows the button, not our own drive.
  localparam logic [TIMER_W-1:0] LINE_SETTLE_CYC = TIMER_W'(4);

  // Supply comparators are analog levels; two flops before use.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pa_s1_q <= 1'b0;
      pa_s2_q <= 1'b0;
      pb_s1_q <= 1'b0;
      pb_s2_q <= 1'b0;
    end
    else
    begin
      pa_s1_q <= primary_above_threshold;
      pa_s2_q <= pa_s1_q;
      pb_s1_q <= primary_above_backup;
      pb_s2_q <= pb_s1_q;
    end
  end

  // Reset line and the oscillator tick are synchronised, then edge detected.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      line_s1_q <= 1'b1;
      line_s2_q <= 1'b1;
      line_prev_q <= 1'b1;
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_prev_q <= 1'b0;
    end
    else
    begin
      line_s1_q <= rst_line_i; // [RQ22]
      line_s2_q <= line_s1_q; // [RQ22]
      line_prev_q <= line_s2_q;
      tick_s1_q <= osc_tick_1hz;
      tick_s2_q <= tick_s1_q;
      tick_prev_q <= tick_s2_q;
    end
  end

  assign fall = line_prev_q & ~line_s2_q; // [RQ22]
  assign rise = ~line_prev_q & line_s2_q; // [RQ22]
  assign tick = tick_s2_q & ~tick_prev_q & osc_run_q;

  // Supply selection and the power fail indication.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      on_primary_q <= 1'b0;
      power_fail_q <= 1'b1;
    end
    else
    begin
      on_primary_q <= pa_s2_q | pb_s2_q; // [RQ3]
      power_fail_q <= ~pa_s2_q; // [RQ5]
    end
  end

  // Oscillator start gating, data retention stop and the first measurement request.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      started_q <= 1'b0;
      osc_run_q <= 1'b0;
      loaded_q <= 1'b0;
      meas_pend_q <= 1'b0;
    end
    else
    begin
      if (!started_q && (pa_s2_q || addr_match))
      begin
        started_q <= 1'b1; // [RQ12]
        osc_run_q <= 1'b1; // [RQ12]
        meas_pend_q <= 1'b1; // [RQ13]
      end
      else if (oscillator_enable_bar && !on_primary_q)
      begin
        osc_run_q <= 1'b0; // [RQ16]
      end
      else if (started_q && (on_primary_q || backup_present))
      begin
        osc_run_q <= 1'b1; // [RQ14]
      end
      else if (!on_primary_q && !backup_present)
      begin
        osc_run_q <= 1'b0;
      end
      if (load_default)
      begin
        loaded_q <= 1'b1;
      end
      if (meas_pend_q && tick && conv_cnt_q == 4'h1)
      begin
        meas_pend_q <= 1'b0; // [RQ13]
      end
    end
  end

  assign load_default = !loaded_q && !started_q && (pa_s2_q || addr_match); // [RQ15]

  // Conversion cadence: each tick on primary, every tenth on backup, first after two ticks.
  assign conv_due = meas_pend_q ? (conv_cnt_q == 4'(FIRST_MEAS_S - 1)) :
                    (on_primary_q ? 1'b1 : (conv_cnt_q == 4'(BACKUP_COMP_PERIOD_S - 1)));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_cnt_q <= CONV_CNT_W0;
      temp_start_q <= 1'b0;
    end
    else
    begin
      temp_start_q <= 1'b0;
      if (tick)
      begin
        if (conv_due)
        begin
          conv_cnt_q <= CONV_CNT_W0;
          temp_start_q <= 1'b1; // [RQ4] [RQ13]
        end
        else
        begin
          conv_cnt_q <= conv_cnt_q + 4'h1; // [RQ4]
        end
      end
    end
  end

  // Correction applied after each conversion: measured value plus trim plus aging offset.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      corr_apply_q <= 1'b0;
      corr_value_q <= '0;
    end
    else
    begin
      corr_apply_q <= temp_done & osc_run_q; // [RQ1]
      if (temp_done && osc_run_q)
      begin
        corr_value_q <= temp_correction + factory_trim + CORR_W'(aging_offset); // [RQ2] [RQ1]
      end
    end
  end

  // Reset line supervisor; it only drives the pin and touches nothing else.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= RTCSS_PFAIL;
      timer_q <= '0;
    end
    else
    begin
      case (state_q)
        RTCSS_IDLE:
        begin
          if (!pa_s2_q)
          begin
            state_q <= RTCSS_PFAIL; // [RQ5]
          end
          else if (fall)
          begin
            state_q <= RTCSS_DEBOUNCE; // [RQ8]
            timer_q <= TIMER_W'(DEBOUNCE_LEN);
          end
        end
        RTCSS_PFAIL:
        begin
          if (pa_s2_q)
          begin
            if (osc_run_q)
            begin
              state_q <= RTCSS_RECOVER; // [RQ6]
              timer_q <= TIMER_W'(RECOVERY_CYC);
            end
            else
            begin
              state_q <= RTCSS_IDLE; // [RQ7]
            end
          end
        end
        RTCSS_RECOVER, RTCSS_DEBOUNCE, RTCSS_PULSE:
        begin
          if (!pa_s2_q)
          begin
            state_q <= RTCSS_PFAIL;
          end
          else if (timer_q > TIMER_W'(1))
          begin
            timer_q <= timer_q - TIMER_W'(1); // [RQ6] [RQ8]
          end
          else if (state_q == RTCSS_DEBOUNCE && !line_s2_q)
          begin
            state_q <= RTCSS_WAIT_RISE; // [RQ9]
          end
          else
          begin
            state_q <= RTCSS_IDLE;
          end
        end
        RTCSS_WAIT_RISE:
        begin
          if (!pa_s2_q)
          begin
            state_q <= RTCSS_PFAIL;
          end
          else if (rise || line_s2_q)
          begin
            state_q <= RTCSS_PULSE; // [RQ9]
            timer_q <= TIMER_W'(PULSE_LEN);
          end
        end
        default:
        begin
          state_q <= RTCSS_PFAIL;
        end
      endcase
    end
  end

  // Without primary the pin sits low; the supervisor drives it low in every active state but RTCSS_WAIT_RISE and the end of RTCSS_DEBOUNCE.
  assign drive_low = !pa_s2_q || (state_q != RTCSS_IDLE && state_q != RTCSS_WAIT_RISE &&
                     !(state_q == RTCSS_DEBOUNCE && timer_q <= LINE_SETTLE_CYC)); // [RQ11] [RQ10] [RQ9]
  assign rst_line_o = 1'b0;
  assign rst_line_oe = ~drive_low;

  // Half second square wave phase and the alarm interrupt flag.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sq_q <= 1'b0;
      alarm_flag_q <= 1'b0;
    end
    else
    begin
      sq_q <= tick_s2_q & osc_run_q;
      alarm_flag_q <= (alarm1_match & alarm1_enable) | (alarm2_match & alarm2_enable); // [RQ19]
    end
  end

  // Open drain multifunction pin: low while driven.
  assign alarm_irq_or_square_o = 1'b0;
  assign alarm_irq_or_square_oe = irq_output_select ? ~alarm_flag_q : sq_q; // [RQ21] [RQ19]

  rtcss_calendar u_cal (
    .clk(clk),
    .arst_n(arst_n),
    .load_default(load_default),
    .tick(tick),
    .mode_12h(mode_12h),
    .sec_q(sec_q),
    .min_q(min_q),
    .hour_q(hour_q),
    .wday_q(wday_q),
    .date_q(date_q),
    .month_q(month_q),
    .year_q(year_q)
  );
endmodule
`default_nettype wire

//--- testbench/rtcss_far_model.sv
// Pushbutton with line pull-up and compensated oscillator on the far side of the supervisor.
`timescale 1ns/1ps
`default_nettype none
module rtcss_far_model (
  input wire logic rst_line_o,
  input wire logic rst_line_oe,
  input wire logic press,
  input wire logic osc_run_q,
  output logic rst_line_i,
  output logic osc_tick_1hz
);
  // The line is pulled high unless the supervisor drives it or the button holds it low.
  assign rst_line_i = !rst_line_oe ? rst_line_o : !press;

  // The oscillator output toggles only while running and rests low when stopped.
  initial
  begin
    osc_tick_1hz = 1'b0;
    forever
    begin
      #80;
      osc_tick_1hz = osc_run_q ? !osc_tick_1hz : 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- testbench/rtcss_monitor.sv
// Concurrent checks on the supervisor ports, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
module rtcss_monitor #(
  parameter int unsigned RECOVERY_CYC = 30,
  parameter int unsigned DEBOUNCE_LEN = 20,
  parameter int unsigned PULSE_LEN = 25
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic temp_done,
  input wire logic [rtcss_pkg::CORR_W-1:0] temp_correction,
  input wire logic [rtcss_pkg::CORR_W-1:0] factory_trim,
  input wire logic signed [rtcss_pkg::TRIM_W-1:0] aging_offset,
  input wire logic irq_output_select,
  input wire logic alarm1_match,
  input wire logic alarm1_enable,
  input wire logic rst_line_o,
  input wire logic rst_line_oe,
  input wire logic alarm_irq_or_square_o,
  input wire logic alarm_irq_or_square_oe,
  input wire logic power_fail_q,
  input wire logic osc_run_q,
  input wire logic temp_start_q,
  input wire logic corr_apply_q,
  input wire logic [rtcss_pkg::CORR_W-1:0] corr_value_q
);
  import rtcss_pkg::*;
  localparam int REC_WIN = 64;
  logic [CORR_W-1:0] corr_sum;

  // Expected correction is the sum with the offset sign-extended.
  assign corr_sum = temp_correction + factory_trim + {{(CORR_W-TRIM_W){aging_offset[TRIM_W-1]}}, aging_offset};

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  AST_PF_LINE: assert property (power_fail_q |-> !rst_line_oe)
    else $error("reset line released during power fail");
  AST_OPEN_DRAIN: assert property (rst_line_o == 1'b0 && alarm_irq_or_square_o == 1'b0)
    else $error("open-drain output drives high");
  AST_REC_HOLD: assert property ($fell(power_fail_q) && $past(osc_run_q) |-> !rst_line_oe [*8])
    else $error("recovery hold too short");
  AST_REC_BOUND: assert property ($fell(power_fail_q) |-> ##[0:REC_WIN] rst_line_oe)
    else $error("reset line never released after recovery");
  AST_NO_HOLD: assert property ($fell(power_fail_q) && !$past(osc_run_q) |-> rst_line_oe)
    else $error("recovery hold not bypassed with oscillator stopped");
  AST_CORR_VAL: assert property (temp_done |=> corr_apply_q && corr_value_q == $past(corr_sum))
    else $error("correction value wrong");
  AST_CORR_ONLY: assert property (!temp_done |=> !corr_apply_q)
    else $error("correction applied without conversion");
  AST_START_RUN: assert property (temp_start_q |-> $past(osc_run_q))
    else $error("conversion started with oscillator stopped");
  AST_ALARM_IRQ: assert property ((irq_output_select && alarm1_enable && alarm1_match) [*2]
    |-> !alarm_irq_or_square_oe)
    else $error("alarm interrupt not asserted");

  COV_RECOVER: cover property ($fell(power_fail_q) && osc_run_q);
  COV_CONVERT: cover property (temp_start_q);
  COV_IRQ: cover property (irq_output_select && !alarm_irq_or_square_oe);
endmodule
bind rtcss_top rtcss_monitor #(.RECOVERY_CYC(RECOVERY_CYC), .DEBOUNCE_LEN(DEBOUNCE_LEN), .PULSE_LEN(PULSE_LEN))
  i_rtcss_monitor (.clk, .arst_n, .temp_done, .temp_correction, .factory_trim, .aging_offset, .irq_output_select,
  .alarm1_match, .alarm1_enable, .rst_line_o, .rst_line_oe, .alarm_irq_or_square_o, .alarm_irq_or_square_oe,
  .power_fail_q, .osc_run_q, .temp_start_q, .corr_apply_q, .corr_value_q);
`default_nettype wire

//--- testbench/tb_top.sv
// Self-checking bench for supply selection, reset supervisor and compensation cadence.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtcss_pkg::*;
  localparam int unsigned REC = 30;
  localparam int unsigned DEB = 20;
  localparam int unsigned PUL = 25;
  logic clk, arst_n, primary_above_threshold, primary_above_backup, backup_present, addr_match, osc_tick_1hz;
  logic temp_done, oscillator_enable_bar, irq_output_select, mode_12h, alarm1_match, alarm2_match;
  logic alarm1_enable, alarm2_enable, rst_line_i, press, rst_line_o, rst_line_oe, alarm_irq_or_square_o;
  logic alarm_irq_or_square_oe, on_primary_q, power_fail_q, osc_run_q, temp_start_q, corr_apply_q;
  logic [CORR_W-1:0] temp_correction, factory_trim, corr_value_q;
  logic signed [TRIM_W-1:0] aging_offset;
  logic [7:0] sec_q, min_q, hour_q, date_q, month_q, year_q;
  logic [2:0] wday_q;
  logic [7:0] offs [3] = '{8'hFD, 8'h05, 8'h81};
  logic [9:0] expv [3] = '{10'h022, 10'h02A, 10'h3A6};
  int n_mismatch, n_compared, g;

  rtcss_top #(.RECOVERY_CYC(REC), .DEBOUNCE_LEN(DEB), .PULSE_LEN(PUL)) i_rtcss_top (.clk, .arst_n,
    .primary_above_threshold, .primary_above_backup, .backup_present, .addr_match, .osc_tick_1hz, .temp_done,
    .temp_correction, .factory_trim, .aging_offset, .oscillator_enable_bar, .irq_output_select, .mode_12h,
    .alarm1_match, .alarm2_match, .alarm1_enable, .alarm2_enable, .rst_line_i, .rst_line_o, .rst_line_oe,
    .alarm_irq_or_square_o, .alarm_irq_or_square_oe, .on_primary_q, .power_fail_q, .osc_run_q, .temp_start_q,
    .corr_apply_q, .corr_value_q, .sec_q, .min_q, .hour_q, .wday_q, .date_q, .month_q, .year_q);
  rtcss_far_model i_rtcss_far_model (.rst_line_o, .rst_line_oe, .press, .osc_run_q, .rst_line_i, .osc_tick_1hz);

  // The clock runs at 100 MHz.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Waits a bounded number of cycles for a chosen output to reach a level.
  task automatic wait_until(input int sel, input logic v, input int lim);
    logic s;
    for (int i = 0; i < lim; i++)
    begin
      @(posedge clk);
      #1;
      case (sel)
        0: s = rst_line_oe;
        1: s = osc_run_q;
        2: s = power_fail_q;
        3: s = temp_start_q;
        default: s = alarm_irq_or_square_oe;
      endcase
      if (s === v)
      begin
        n_compared++;
        return;
      end
    end
    n_mismatch++;
    $display("MISMATCH t=%0t got=%h exp=%h", $time, s, v);
    wrap_up();
  endtask

  // Counts cycles while the supervisor keeps the line driven low.
  task automatic low_len(output int c);
    c = 0;
    while (rst_line_oe === 1'b0 && c < 300)
    begin
      @(posedge clk);
      #1;
      c++;
    end
  endtask

  // Measures cycles between two conversion starts.
  task automatic gap(output int c);
    wait_until(3, 1'b1, 400);
    c = 0;
    do
    begin
      @(posedge clk);
      #1;
      c++;
    end while (temp_start_q !== 1'b1 && c < 400);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("compared=%0d mismatches=%0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence of tests.
  initial
  begin
    {arst_n, primary_above_threshold, primary_above_backup, addr_match, temp_done, press} = '0;
    {oscillator_enable_bar, mode_12h, alarm1_match, alarm2_match, alarm1_enable, alarm2_enable} = '0;
    backup_present = 1'b1;
    irq_output_select = 1'b1;
    mode_12h = 1'b1;
    temp_correction = 10'h005;
    factory_trim = 10'h020;
    aging_offset = 8'h00;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk(osc_run_q, 0);
    chk(rst_line_oe, 0);
    chk(on_primary_q, 0);
    @(posedge clk);
    addr_match <= 1'b1;
    @(posedge clk);
    addr_match <= 1'b0;
    wait_until(1, 1'b1, 4);
    chk({date_q, month_q, year_q}, 24'h010100);
    chk({wday_q, hour_q, min_q, sec_q}, {3'h1, 8'h52, 16'h0000});
    gap(g);
    chk(g, 160);
    chk(sec_q, 8'h12);
    $display("done: backup start and cadence");
    @(posedge clk);
    primary_above_threshold <= 1'b1;
    primary_above_backup <= 1'b1;
    wait_until(2, 1'b0, 6);
    chk(on_primary_q, 1);
    low_len(g);
    chk(g > REC - 6 && g < REC + 4, 1);
    gap(g);
    chk(g, 16);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      aging_offset <= offs[k];
      temp_done <= 1'b1;
      @(posedge clk);
      temp_done <= 1'b0;
      #1;
      chk({corr_apply_q, corr_value_q}, {1'b1, expv[k]});
    end
    $display("done: primary recovery and correction");
    @(posedge clk);
    primary_above_threshold <= 1'b0;
    wait_until(2, 1'b1, 6);
    chk({on_primary_q, rst_line_oe}, 2'b10);
    @(posedge clk);
    primary_above_backup <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk(on_primary_q, 0);
    @(posedge clk);
    primary_above_threshold <= 1'b1;
    wait_until(0, 1'b1, REC + 10);
    chk(on_primary_q, 1);
    $display("done: supply selection");
    @(posedge clk);
    press <= 1'b1;
    wait_until(0, 1'b0, 6);
    repeat (DEB + 10) @(posedge clk);
    #1;
    chk(rst_line_oe, 1);
    @(posedge clk);
    press <= 1'b0;
    wait_until(0, 1'b0, 6);
    low_len(g);
    chk(g > PUL - 4 && g < PUL + 3, 1);
    @(posedge clk);
    press <= 1'b1;
    repeat (2) @(posedge clk);
    press <= 1'b0;
    wait_until(0, 1'b0, 6);
    low_len(g);
    chk(g > DEB - 6 && g < DEB + 3, 1);
    // A button let go during debounce must not be followed by a reset pulse.
    g = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1;
      g += (rst_line_oe !== 1'b1);
    end
    chk(g, 0);
    $display("done: pushbutton");
    @(posedge clk);
    alarm1_enable <= 1'b1;
    alarm1_match <= 1'b1;
    wait_until(4, 1'b0, 4);
    @(posedge clk);
    alarm1_match <= 1'b0;
    alarm2_match <= 1'b1;
    wait_until(4, 1'b1, 4);
    repeat (4) @(posedge clk);
    #1;
    chk(alarm_irq_or_square_oe, 1);
    @(posedge clk);
    irq_output_select <= 1'b0;
    wait_until(4, 1'b0, 40);
    wait_until(4, 1'b1, 40);
    $display("done: alarm and square output");
    @(posedge clk);
    primary_above_threshold <= 1'b0;
    oscillator_enable_bar <= 1'b1;
    wait_until(1, 1'b0, 8);
    chk(rst_line_oe, 0);
    @(posedge clk);
    primary_above_threshold <= 1'b1;
    wait_until(0, 1'b1, 6);
    $display("done: retention and bypass");
    wrap_up();
  end
endmodule
`default_nettype wire
